// ---- pkg/eqws_pkg.sv ----
package eqws_pkg;

  // ---------------------------------------------------------------------------
  // Register page and offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] EQWS_PAGE          = 8'h30;
  localparam logic [7:0] EQWS_OFF_MODE      = 8'h80;
  localparam logic [7:0] EQWS_OFF_WEIGHT0   = 8'h81;
  localparam logic [7:0] EQWS_OFF_C4_LO     = 8'h85;
  localparam logic [7:0] EQWS_OFF_C4_HI     = 8'h86;

  // ---------------------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------------------
  localparam int         EQWS_MODE_LSB      = 0;
  localparam int         EQWS_MODE_W        = 2;
  localparam int         EQWS_C4_STRICT_BIT = 0;
  localparam int         EQWS_NUM_BE        = 4;
  localparam int         EQWS_WEIGHT_W      = 8;
  localparam int         EQWS_QID_W         = 3;

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] EQWS_RST_MODE_REG  = 8'h00;
  localparam logic [7:0] EQWS_RST_WEIGHT0   = 8'h01;
  localparam logic [7:0] EQWS_RST_WEIGHT1   = 8'h02;
  localparam logic [7:0] EQWS_RST_WEIGHT2   = 8'h04;
  localparam logic [7:0] EQWS_RST_WEIGHT3   = 8'h08;
  localparam logic       EQWS_RST_C4_STRICT = 1'b1;
  localparam logic [7:0] EQWS_RST_C4_RATIO  = 8'h01;

  // ---------------------------------------------------------------------------
  // Queue identifiers of the two time sensitive classes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] EQWS_QID_C4        = 3'h4;
  localparam logic [2:0] EQWS_QID_C5        = 3'h5;

  typedef enum logic [1:0] {
    EQWS_MODE_ALL_WRR  = 2'h0,
    EQWS_MODE_Q3_SP    = 2'h1,
    EQWS_MODE_Q32_SP   = 2'h2,
    EQWS_MODE_ALL_SP   = 2'h3
  } eqws_mode_e;

  // Strict-priority mask of the best-effort queues for a given mode.
  function automatic logic [3:0] eqws_strict_mask(input logic [1:0] mode);
    logic [3:0] m;
    m = 4'h0;
    case (mode)
      EQWS_MODE_ALL_WRR: m = 4'h0;
      EQWS_MODE_Q3_SP:   m = 4'h8;
      EQWS_MODE_Q32_SP:  m = 4'hc;
      EQWS_MODE_ALL_SP:  m = 4'hf;
      default:           m = 4'h0;
    endcase
    return m;
  endfunction

endpackage

// ---- hw/eqws_be_sched.sv ----
module eqws_be_sched #(
  parameter int NQ = 4,
  parameter int WW = 8
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Queue state and configuration
  input  wire logic [NQ-1:0]          nonempty_i,
  input  wire logic [NQ-1:0]          strict_i,
  input  wire logic [NQ*WW-1:0]       weights_i,
  // Pick and consume
  input  wire logic                   take_i,
  output logic                        pick_valid_o,
  output logic [$clog2(NQ)-1:0]       pick_q_o
);

  localparam int QW = $clog2(NQ);

  if (NQ < 2 || (1 << QW) != NQ) begin : g_chk
    $error("eqws_be_sched: NQ must be a power of two of at least 2");
  end

  logic [WW-1:0] credit_q [NQ];
  logic [QW-1:0] ptr_q;
  logic [NQ-1:0] sp_set;
  logic [NQ-1:0] wrr_set;
  logic [NQ-1:0] has_credit;
  logic [NQ-1:0] elig;
  logic          reload;
  logic          sp_hit;
  logic [QW-1:0] sp_q;
  logic          wrr_hit;
  logic [QW-1:0] wrr_q;

  assign sp_set  = nonempty_i & strict_i;
  assign wrr_set = nonempty_i & ~strict_i;

  for (genvar g = 0; g < NQ; g++) begin : g_cred
    assign has_credit[g] = credit_q[g] != '0;
  end

  assign reload = ((wrr_set & has_credit) == '0) && (wrr_set != '0);
  assign elig   = reload ? wrr_set : (wrr_set & has_credit);

  always_comb begin
    sp_hit = 1'b0;
    sp_q   = '0;
    for (int i = 0; i < NQ; i++) begin
      if (sp_set[i]) begin
        sp_hit = 1'b1;
        sp_q   = QW'(i);
      end
    end
  end

  always_comb begin
    logic [QW-1:0] idx;
    idx     = '0;
    wrr_hit = 1'b0;
    wrr_q   = '0;
    for (int k = 0; k < NQ; k++) begin
      idx = QW'(int'(ptr_q) + k);
      if (!wrr_hit && elig[idx]) begin
        wrr_hit = 1'b1;
        wrr_q   = idx;
      end
    end
  end

  assign pick_valid_o = sp_hit | wrr_hit;
  assign pick_q_o     = sp_hit ? sp_q : wrr_q;

  // The pointer stays on the served queue so it spends its whole credit in a burst.
  // packets per round
  for (genvar g = 0; g < NQ; g++) begin : g_upd
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        credit_q[g] <= '0;
      end else if (take_i && !sp_hit && wrr_hit) begin
        if (wrr_q == QW'(g)) begin
          credit_q[g] <= (reload ? weights_i[g*WW +: WW] : credit_q[g]) - WW'(1);
        end else if (reload) begin
          credit_q[g] <= weights_i[g*WW +: WW];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= '0;
    end else if (take_i && !sp_hit && wrr_hit) begin
      ptr_q <= wrr_q;
    end
  end

endmodule

// ---- hw/eqws_top.sv ----
module eqws_top
  import eqws_pkg::*;
(
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        nrst_i,
  // Paged register port
  input  wire logic [7:0]                  reg_page_i,
  input  wire logic [7:0]                  reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [7:0]                  reg_wdata_i,
  output logic      [7:0]                  reg_rdata_o,
  // Queue state
  input  wire logic [5:0]                  q_nonempty_i,
  // Transmit side
  input  wire logic                        tx_req_i,
  output logic                             sel_done_o,
  output logic                             sel_hit_o,
  output logic      [eqws_pkg::EQWS_QID_W-1:0] sel_qid_o
);
  import eqws_pkg::*;

  localparam int NB = EQWS_NUM_BE;
  localparam int WW = EQWS_WEIGHT_W;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0]      mode_reg_q;
  logic [WW-1:0]   weight_q [NB];
  logic            c4_strict_q;
  logic [7:0]      c4_ratio_q;
  logic [7:0]      c4_cnt_q;

  logic            page_hit;
  logic            wr_mode;
  logic            wr_c4_lo;
  logic            wr_c4_hi;
  logic [NB-1:0]   wr_weight;
  logic [NB*WW-1:0] weights_flat;
  logic [7:0]      rd_mux;

  assign page_hit = reg_page_i == EQWS_PAGE;
  assign wr_mode  = reg_wr_i && page_hit && (reg_addr_i == EQWS_OFF_MODE);
  assign wr_c4_lo = reg_wr_i && page_hit && (reg_addr_i == EQWS_OFF_C4_LO);
  assign wr_c4_hi = reg_wr_i && page_hit && (reg_addr_i == EQWS_OFF_C4_HI);

  function automatic logic [WW-1:0] weight_rst(input int q);
    logic [WW-1:0] v;
    v = EQWS_RST_WEIGHT0;
    case (q)
      1:       v = EQWS_RST_WEIGHT1;
      2:       v = EQWS_RST_WEIGHT2;
      3:       v = EQWS_RST_WEIGHT3;
      default: v = EQWS_RST_WEIGHT0;
    endcase
    return v;
  endfunction

  for (genvar g = 0; g < NB; g++) begin : g_w
    assign wr_weight[g] = reg_wr_i && page_hit && (reg_addr_i == EQWS_OFF_WEIGHT0 + 8'(g));
    assign weights_flat[g*WW +: WW] = weight_q[g];
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        weight_q[g] <= weight_rst(g);
      end else if (wr_weight[g]) begin
        weight_q[g] <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg_q <= EQWS_RST_MODE_REG;
    end else if (wr_mode) begin
      mode_reg_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      c4_strict_q <= EQWS_RST_C4_STRICT;
      c4_ratio_q  <= EQWS_RST_C4_RATIO;
    end else begin
      if (wr_c4_hi) begin
        c4_strict_q <= reg_wdata_i[EQWS_C4_STRICT_BIT];
      end
      if (wr_c4_lo) begin
        c4_ratio_q <= reg_wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (page_hit) begin
      case (reg_addr_i)
        EQWS_OFF_MODE:      rd_mux = mode_reg_q;
        EQWS_OFF_WEIGHT0:   rd_mux = weight_q[0];
        EQWS_OFF_WEIGHT0 + 8'h1: rd_mux = weight_q[1];
        EQWS_OFF_WEIGHT0 + 8'h2: rd_mux = weight_q[2];
        EQWS_OFF_WEIGHT0 + 8'h3: rd_mux = weight_q[3];
        EQWS_OFF_C4_LO:     rd_mux = c4_ratio_q;
        EQWS_OFF_C4_HI:     rd_mux = {7'h00, c4_strict_q};
        default:            rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------------
  // Best-effort group
  // ---------------------------------------------------------------------------
  logic [1:0]    mode;
  logic [NB-1:0] strict_set;
  logic          be_valid;
  logic [1:0]    be_q;
  logic          be_take;

  assign mode = mode_reg_q[EQWS_MODE_LSB +: EQWS_MODE_W];
  assign strict_set = eqws_strict_mask(mode);

  eqws_be_sched #(
    .NQ (NB),
    .WW (WW)
  ) u_be (
    .clk_i        (ref_clk_i),
    .nrst_i       (nrst_i),
    .nonempty_i   (q_nonempty_i[NB-1:0]),
    .strict_i     (strict_set),
    .weights_i    (weights_flat),
    .take_i       (be_take),
    .pick_valid_o (be_valid),
    .pick_q_o     (be_q)
  );

  // ---------------------------------------------------------------------------
  // Class arbitration
  // ---------------------------------------------------------------------------
  logic c5_pend;
  logic c4_pend;
  logic c4_wins;
  logic pick_c5;
  logic pick_c4;
  logic pick_be;
  logic [EQWS_QID_W-1:0] pick_qid;

  assign c5_pend = q_nonempty_i[5];
  assign c4_pend = q_nonempty_i[4];
  assign c4_wins = c4_strict_q || !be_valid || (c4_cnt_q < c4_ratio_q);
  assign pick_c5 = c5_pend;
  assign pick_c4 = !c5_pend && c4_pend && c4_wins;
  assign pick_be = !c5_pend && !pick_c4 && be_valid;
  assign be_take = tx_req_i && pick_be;
  assign pick_qid = pick_c5 ? EQWS_QID_C5 :
                    pick_c4 ? EQWS_QID_C4 : {1'b0, be_q};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      c4_cnt_q <= 8'h00;
    end else if (tx_req_i && pick_be) begin
      c4_cnt_q <= 8'h00;
    end else if (tx_req_i && pick_c4 && !c4_strict_q && be_valid) begin
      c4_cnt_q <= c4_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_done_o <= 1'b0;
      sel_hit_o  <= 1'b0;
      sel_qid_o  <= '0;
    end else begin
      sel_done_o <= tx_req_i;
      if (tx_req_i) begin
        sel_hit_o <= pick_c5 | pick_c4 | pick_be;
        sel_qid_o <= pick_qid;
      end
    end
  end

endmodule

// ---- verif/eqws_props.sv ----
module eqws_props
  import eqws_pkg::*;
(
  // Clock and reset
  input wire logic                        ref_clk_i,
  input wire logic                        nrst_i,
  // Register port
  input wire logic [7:0]                  reg_page_i,
  input wire logic [7:0]                  reg_addr_i,
  input wire logic                        reg_wr_i,
  input wire logic [7:0]                  reg_wdata_i,
  // Choice port
  input wire logic [5:0]                  q_nonempty_i,
  input wire logic                        tx_req_i,
  input wire logic                        sel_done_o,
  input wire logic                        sel_hit_o,
  input wire logic [eqws_pkg::EQWS_QID_W-1:0] sel_qid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q;
  logic       c4s_q;
  logic [2:0] hi_be;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Shadow of the scheduling controls, written on the block's page only.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= 2'h0;
      c4s_q  <= 1'b1;
    end else if (reg_wr_i && reg_page_i == 8'h30) begin
      if (reg_addr_i == 8'h80) mode_q <= reg_wdata_i[1:0];
      if (reg_addr_i == 8'h86) c4s_q <= reg_wdata_i[0];
    end
  end
  assign hi_be = q_nonempty_i[3] ? 3'h3 : q_nonempty_i[2] ? 3'h2 : q_nonempty_i[1] ? 3'h1 : 3'h0;
  property p_done; tx_req_i |=> sel_done_o; endproperty
  a_done: assert property (p_done) else $error("no answer to request");
  property p_quiet; !tx_req_i |=> !sel_done_o; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_c5; tx_req_i && q_nonempty_i[5] |=> sel_hit_o && sel_qid_o == 3'h5; endproperty
  a_c5: assert property (p_c5) else $error("class five not served");
  property p_c4sp; tx_req_i && c4s_q && q_nonempty_i[5:4] == 2'h1 |=> sel_qid_o == 3'h4; endproperty
  a_c4sp: assert property (p_c4sp) else $error("class four not strict");
  property p_idle; tx_req_i && q_nonempty_i == 6'h00 |=> !sel_hit_o; endproperty
  a_idle: assert property (p_idle) else $error("hit with all empty");
  property p_skip; sel_done_o && sel_hit_o |-> ($past(q_nonempty_i) & (6'h01 << sel_qid_o)) != 6'h00; endproperty
  a_skip: assert property (p_skip) else $error("empty queue chosen");
  property p_allsp;
    tx_req_i && mode_q == 2'h3 && q_nonempty_i[5:4] == 2'h0 && q_nonempty_i[3:0] != 4'h0
      |=> sel_qid_o == $past(hi_be);
  endproperty
  a_allsp: assert property (p_allsp) else $error("strict order broken");
  property p_q3sp; tx_req_i && mode_q != 2'h0 && q_nonempty_i[5:3] == 3'h1 |=> sel_qid_o == 3'h3; endproperty
  a_q3sp: assert property (p_q3sp) else $error("queue three not strict");
endmodule

bind eqws_top eqws_props u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_page_i(reg_page_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .q_nonempty_i(q_nonempty_i), .tx_req_i(tx_req_i), .sel_done_o(sel_done_o),
  .sel_hit_o(sel_hit_o), .sel_qid_o(sel_qid_o));

// ---- verif/eqws_port_model.sv ----
module eqws_port_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Load of queue fill and request budget
  input  wire logic        ld_i,
  input  wire logic [23:0] cnt_i,
  input  wire logic [4:0]  n_i,
  // Answer from the scheduler
  input  wire logic        sel_done_i,
  input  wire logic        sel_hit_i,
  input  wire logic [2:0]  sel_qid_i,
  // Queue state and requests
  output logic [5:0]       q_nonempty_o,
  output logic             tx_req_o,
  output logic             idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] c_q [6];
  logic [4:0] n_q;
  logic       busy_q;
  assign q_nonempty_o = {c_q[5] != 0, c_q[4] != 0, c_q[3] != 0, c_q[2] != 0, c_q[1] != 0, c_q[0] != 0};
  assign idle_o = n_q == 5'h00 && !busy_q && !tx_req_o;
  // One request in flight; the queue fill is updated before the next one.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      n_q <= 5'h00;
      busy_q <= 1'b0;
      tx_req_o <= 1'b0;
      for (int i = 0; i < 6; i++) c_q[i] <= 4'h0;
    end else begin
      tx_req_o <= 1'b0;
      if (ld_i) begin
        n_q <= n_i;
        for (int i = 0; i < 6; i++) c_q[i] <= cnt_i[4*i+:4];
      end else if (!busy_q && !tx_req_o && n_q != 5'h00) begin
        tx_req_o <= 1'b1;
        busy_q <= 1'b1;
        n_q <= n_q - 5'h01;
      end
      if (sel_done_i) begin
        busy_q <= 1'b0;
        if (sel_hit_i && c_q[sel_qid_i] != 4'h0) c_q[sel_qid_i] <= c_q[sel_qid_i] - 4'h1;
      end
    end
  end
endmodule

// ---- verif/egress_queue_weight_scheduler_bench.sv ----
module egress_queue_weight_scheduler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, nrst = 1'b1, wr = 1'b0, rd = 1'b0, ld = 1'b0;
  logic [7:0]  page = 8'h30, addr = 8'h00, wdata = 8'h00, rdata;
  logic [5:0]  ne;
  logic        tx_req, done, hit, idle;
  logic [2:0]  qid;
  logic [23:0] ld_cnt = 24'h0;
  logic [4:0]  ld_n = 5'h00;
  logic [3:0]  srv [6];
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  eqws_top u_dut (.ref_clk_i(clk), .nrst_i(nrst), .reg_page_i(page), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .q_nonempty_i(ne),
    .tx_req_i(tx_req), .sel_done_o(done), .sel_hit_o(hit), .sel_qid_o(qid));
  eqws_port_model u_model (.clk_i(clk), .nrst_i(nrst), .ld_i(ld), .cnt_i(ld_cnt), .n_i(ld_n),
    .sel_done_i(done), .sel_hit_i(hit), .sel_qid_i(qid), .q_nonempty_o(ne), .tx_req_o(tx_req),
    .idle_o(idle));
  always @(posedge clk) if (done === 1'b1 && hit === 1'b1) srv[qid] <= srv[qid] + 4'h1;
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    page <= pg;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    page <= 8'h30;
    #1 chk({16'h0, rdata}, {16'h0, exp});
  endtask
  // Loads queue fill, runs n choices and compares packets served per queue.
  // Credits and the round pointer carry over from the scenario before.
  task automatic scen(input logic [1:0] m, input logic [23:0] l, input logic [4:0] n,
                      input logic [23:0] exp);
    logic [23:0] got;
    int          k;
    wr_reg(8'h80, {6'h0, m});
    @(posedge clk);
    ld <= 1'b1;
    ld_cnt <= l;
    ld_n <= n;
    for (int j = 0; j < 6; j++) srv[j] <= 4'h0;
    @(posedge clk);
    ld <= 1'b0;
    k = 0;
    #1 while (idle !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1 k++;
    end
    chk({23'h0, idle}, 24'h000001);
    for (int j = 0; j < 6; j++) got[4*j+:4] = srv[j];
    chk(got, exp);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h30, 8'h80, 8'h00);
    rd_reg(8'h30, 8'h81, 8'h01);
    rd_reg(8'h30, 8'h82, 8'h02);
    rd_reg(8'h30, 8'h83, 8'h04);
    rd_reg(8'h30, 8'h84, 8'h08);
    rd_reg(8'h30, 8'h85, 8'h01);
    rd_reg(8'h30, 8'h86, 8'h01);
    rd_reg(8'h31, 8'h81, 8'h00);
    scen(2'h0, 24'h00ffff, 5'h0f, 24'h008421);
    scen(2'h0, 24'h00fff0, 5'h0e, 24'h008420);
    wr_reg(8'h82, 8'h03);
    wr_reg(8'h83, 8'h05);
    rd_reg(8'h30, 8'h82, 8'h03);
    scen(2'h0, 24'h00ffff, 5'h11, 24'h007532);
    scen(2'h1, 24'h003fff, 5'h0c, 24'h003531);
    scen(2'h2, 24'h0032ff, 5'h09, 24'h003231);
    scen(2'h3, 24'h004321, 5'h0b, 24'h004321);
    scen(2'h0, 24'h02ffff, 5'h13, 24'h02c500);
    wr_reg(8'h86, 8'hff);
    rd_reg(8'h30, 8'h86, 8'h01);
    wr_reg(8'h86, 8'h00);
    wr_reg(8'h85, 8'h02);
    rd_reg(8'h30, 8'h85, 8'h02);
    scen(2'h0, 24'h0f8000, 5'h09, 24'h063000);
    scen(2'h3, 24'h250000, 5'h04, 24'h220000);
    close_out;
  end
endmodule
